//--- rtl/vref_consts.svh
// Offsets, field positions, reset values and timing counts of the reference control core
`ifndef VREF_CONSTS_SVH
`define VREF_CONSTS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define TELEM_ACK_NS 100
`define TELEM_ACK_CYC 4'((`TELEM_ACK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLEW_DIV_RESET 8'h0a

// ----------------------------------------------------------------
// Code decoding, 6.25 mV per step
// ----------------------------------------------------------------
`define CODE_ZERO_STEPS 8'hf8
`define CODE_OFF_MIN 8'hf9
`define FRAME_BITS 4'ha
`define FRAME_SEL_CORE 9
`define FRAME_SEL_NB 8

// ----------------------------------------------------------------
// Converter channels and protection limits
// ----------------------------------------------------------------
`define ADC_LAST_CH 4'h8
`define ADC_CH_CORE_CURR 5
`define ADC_CH_NB_CURR 6
`define ADC_CH_CORE_SENSE 7
`define ADC_CH_NB_SENSE 8
`define OV_MARGIN 10'h010
`define UV_MARGIN 10'h010
`define NV_LIMIT 10'h3f0
`define OC_LIMIT_RESET 10'h200
`define FLT_OC 3
`define FLT_OV 2
`define FLT_UV 1
`define FLT_NV 0

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_OC_LIMIT 8'h04
`define REG_STATUS 8'h08
`define REG_FAULT 8'h0c
`define REG_IRQ_STATUS 8'h10
`define REG_IRQ_CLEAR 8'h14
`define REG_IRQ_ENABLE 8'h18
`define REG_ADC_BASE 8'h20
`define REG_ADC_END 8'h44
`define CTRL_PROT_EN_BIT 8
`define STAT_NB_LSB 8
`define STAT_CORE_OFF_BIT 16
`define STAT_NB_OFF_BIT 17
`define STAT_STATE_LSB 24
`define IRQ_FRAME 0
`define IRQ_SS_DONE 1
`define IRQ_FAULT 2
`define IRQ_OCP 3
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

//--- rtl/vref_pkg.sv
// Types shared by the reference control core and its link receiver
package vref_pkg;

  typedef enum logic [1:0] {
    SS_IDLE = 2'b00,
    SS_SOFT = 2'b01,
    SS_RUN = 2'b10
  } ss_state_t;

  typedef struct packed {
    logic valid;
    logic [1:0] sel;
    logic [7:0] code;
  } frame_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;

  typedef struct packed {
    logic s1c, s2c, dc, s1d, s2d, dd;
    logic armed;
    logic [3:0] cnt;
    logic [9:0] shift;
    frame_t frame;
  } rx_state_t;

  typedef struct packed {
    logic u1, u2, e1, e2;
    ss_state_t st;
    logic [7:0] core_tgt, nb_tgt, core_ref, nb_ref;
    logic core_off, nb_off;
    logic [7:0] slew_cnt, slew_div;
    logic prot_en;
    logic [9:0] oc_lim;
    logic [3:0] core_flt, nb_flt;
    logic [3:0] adc_sel;
    logic adc_start, adc_busy;
    logic [8:0][9:0] adc_res;
    logic core_pg, nb_pg, ocp_n, telem;
    logic [3:0] telem_cnt;
    logic [3:0] irq_stat, irq_en;
    logic irq;
    logic aw_ok, w_ok;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    axi_rsp_t rsp;
  } ctl_state_t;

endpackage

//--- rtl/link_rx.sv
// Serial command link receiver: start, ten bits, one frame pulse
`timescale 1ns/100ps
`default_nettype none
`include "vref_consts.svh"

module link_rx
  import vref_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link pins
  input wire logic serial_vid_clock_pin,
  input wire logic serial_vid_data_pin,
  // Decoded frame
  output var frame_t frame
);

  rx_state_t r, next_r;

  always_comb begin
    next_r = r;
    next_r.frame.valid = 1'b0;
    // Pins are asynchronous to aclk
    next_r.s1c = serial_vid_clock_pin;
    next_r.s2c = r.s1c;
    next_r.dc = r.s2c;
    next_r.s1d = serial_vid_data_pin;
    next_r.s2d = r.s1d;
    next_r.dd = r.s2d;
    if (r.s2c && r.dc && r.dd && !r.s2d) begin
      // Data falling under a high clock opens a frame
      next_r.armed = 1'b1;
      next_r.cnt = 4'h0;
    end else if (r.armed && r.s2c && r.dc && !r.dd && r.s2d) begin
      // Data rising under a high clock aborts a partial frame
      next_r.armed = 1'b0;
    end else if (r.armed && r.s2c && !r.dc) begin
      next_r.shift = {r.shift[8:0], r.s2d};
      next_r.cnt = r.cnt + 4'h1;
      if (r.cnt == `FRAME_BITS - 4'h1) begin
        next_r.armed = 1'b0;
        next_r.frame.valid = 1'b1;
        next_r.frame.sel = {r.shift[`FRAME_SEL_CORE - 1], r.shift[`FRAME_SEL_NB - 1]};
        next_r.frame.code = {r.shift[6:0], r.s2d};
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign frame = r.frame;

  property p_frame_pulse;
    @(posedge aclk) disable iff (!aresetn)
    frame.valid |=> !frame.valid ##1 !frame.valid;
  endproperty
  a_frame_pulse: assert property (p_frame_pulse) else $error("frame pulse too long");

endmodule
`default_nettype wire

//--- rtl/voltage_code_reference_control.sv
// Reference control core: code decode, slew, soft-start, protection, registers
// What this block does
// - A code maps to a target of 1.55 V less 6.25 mV per count, down to 0 V at f8.
// - Codes f9 to ff ask for the rail to be turned off, on either rail.
// - Link codes set separate references for the core rail and the north rail.
// - Commands come over the serial clock and data pins, and acknowledge on telemetry.
// - Soft-start begins only with enable high and no supply lockout; else it waits.
// - Power-good and the overcurrent flag follow protection only after soft-start.
// - An overcurrent on either rail pulls the active-low overcurrent flag low.
// - A reference walks to a new target one step per slew tick; it drops to zero when the controller returns to idle.
// - Nine analogue sources share one converter, scanned in turn, results kept.
// - Supply lockout stops the regulator and acts as power-on reset for the rail targets and off flags only.
// - Each rail raises over-, under-, negative-voltage and overcurrent faults.
// - A high enable pin enables the controller and a low one disables it.
`timescale 1ns/100ps
`default_nettype none
`include "vref_consts.svh"

module voltage_code_reference_control
  import vref_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control pins, asynchronous
  input wire logic enable_pin,
  input wire logic supply_undervoltage_lockout,
  // Serial link
  input wire logic serial_vid_clock_pin,
  input wire logic serial_vid_data_pin,
  output logic serial_telemetry_pin,
  // Shared converter
  output logic [3:0] adc_select,
  output logic adc_start,
  input wire logic [9:0] adc_code,
  input wire logic adc_done,
  // References
  output logic [7:0] core_reference,
  output logic core_off,
  output logic [7:0] nb_reference,
  output logic nb_off,
  // Indicators
  output logic core_power_good,
  output logic nb_power_good,
  output logic overcurrent_flag_n,
  output logic irq,
  // Register bus
  input wire axi_req_t axi_req,
  output var axi_rsp_t axi_rsp
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_off_code(input logic [7:0] code);
    return code >= `CODE_OFF_MIN;
  endfunction

  function automatic logic [7:0] code_to_steps(input logic [7:0] code);
    return `CODE_ZERO_STEPS - code;
  endfunction

  function automatic logic [7:0] step_toward(input logic [7:0] cur, input logic [7:0] goal);
    if (cur < goal) begin
      return cur + 8'h01;
    end else if (cur > goal) begin
      return cur - 8'h01;
    end
    return cur;
  endfunction

  // Returns {oc, ov, uv, nv}; sense codes are signed, 6.25 mV per count
  function automatic logic [3:0] rail_faults(input logic [7:0] ref_steps,
                                             input logic [9:0] sense,
                                             input logic [9:0] curr,
                                             input logic [9:0] lim);
    logic signed [9:0] v;
    logic signed [9:0] refv;
    logic [3:0] f;
    v = $signed(sense);
    refv = $signed({2'b00, ref_steps});
    f = 4'h0;
    f[`FLT_OC] = curr > lim;
    f[`FLT_OV] = v > refv + $signed(`OV_MARGIN);
    f[`FLT_UV] = v < refv - $signed(`UV_MARGIN);
    f[`FLT_NV] = v < $signed(`NV_LIMIT);
    return f;
  endfunction

  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // Link receiver
  // ----------------------------------------------------------------
  frame_t frame;

  link_rx rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .serial_vid_clock_pin(serial_vid_clock_pin),
    .serial_vid_data_pin(serial_vid_data_pin),
    .frame(frame)
  );

  // ----------------------------------------------------------------
  // State update
  // ----------------------------------------------------------------
  ctl_state_t r, next_r;
  logic tick;
  logic wr_fire;
  logic [7:0] core_goal, nb_goal, waddr, raddr;
  logic [3:0] core_f, nb_f, events, clr, aidx;
  logic [31:0] wmerged;

  always_comb begin
    next_r = r;
    events = 4'h0;
    clr = 4'h0;
    // Two flip-flops before the lockout or enable pin is read
    next_r.u1 = supply_undervoltage_lockout;
    next_r.u2 = r.u1;
    next_r.e1 = enable_pin;
    next_r.e2 = r.e1;

    // Frames ignored while the supply is locked out
    if (frame.valid && !r.u2) begin
      events[`IRQ_FRAME] = 1'b1;
      next_r.telem_cnt = `TELEM_ACK_CYC;
      if (frame.sel[1]) begin
        next_r.core_off = is_off_code(frame.code);
        if (!is_off_code(frame.code)) begin
          next_r.core_tgt = code_to_steps(frame.code);
        end
      end
      if (frame.sel[0]) begin
        next_r.nb_off = is_off_code(frame.code);
        if (!is_off_code(frame.code)) begin
          next_r.nb_tgt = code_to_steps(frame.code);
        end
      end
    end else if (r.telem_cnt != 4'h0) begin
      next_r.telem_cnt = r.telem_cnt - 4'h1;
    end
    next_r.telem = (next_r.telem_cnt == 4'h0);

    // Slew ticks; an off rail walks down to zero rather than dropping
    tick = (r.slew_cnt == r.slew_div);
    next_r.slew_cnt = tick ? 8'h00 : r.slew_cnt + 8'h01;
    core_goal = r.core_off ? 8'h00 : r.core_tgt;
    nb_goal = r.nb_off ? 8'h00 : r.nb_tgt;
    core_f = rail_faults(r.core_ref, r.adc_res[`ADC_CH_CORE_SENSE],
                         r.adc_res[`ADC_CH_CORE_CURR], r.oc_lim);
    nb_f = rail_faults(r.nb_ref, r.adc_res[`ADC_CH_NB_SENSE],
                       r.adc_res[`ADC_CH_NB_CURR], r.oc_lim);

    case (r.st)
      SS_IDLE: begin
        next_r.core_ref = 8'h00;
        next_r.nb_ref = 8'h00;
        next_r.core_flt = 4'h0;
        next_r.nb_flt = 4'h0;
        if (r.e2 && !r.u2) begin
          next_r.st = SS_SOFT;
        end
      end
      SS_SOFT: begin
        if (tick) begin
          next_r.core_ref = step_toward(r.core_ref, core_goal);
          next_r.nb_ref = step_toward(r.nb_ref, nb_goal);
        end
        if (r.core_ref == core_goal && r.nb_ref == nb_goal) begin
          next_r.st = SS_RUN;
          events[`IRQ_SS_DONE] = 1'b1;
        end
      end
      SS_RUN: begin
        if (tick) begin
          next_r.core_ref = step_toward(r.core_ref, core_goal);
          next_r.nb_ref = step_toward(r.nb_ref, nb_goal);
        end
        // Faults latch until the controller is disabled or locked out
        if (r.prot_en && !r.core_off) begin
          next_r.core_flt = r.core_flt | core_f;
        end
        if (r.prot_en && !r.nb_off) begin
          next_r.nb_flt = r.nb_flt | nb_f;
        end
        events[`IRQ_FAULT] = (next_r.core_flt != r.core_flt) || (next_r.nb_flt != r.nb_flt);
        events[`IRQ_OCP] = (next_r.core_flt[`FLT_OC] && !r.core_flt[`FLT_OC])
                        || (next_r.nb_flt[`FLT_OC] && !r.nb_flt[`FLT_OC]);
      end
      default: begin
        next_r.st = SS_IDLE;
      end
    endcase

    if (!r.e2 || r.u2) begin
      next_r.st = SS_IDLE;
    end
    if (r.u2) begin
      // Lockout acts as power-on reset for the targets
      next_r.core_off = 1'b1;
      next_r.nb_off = 1'b1;
      next_r.core_tgt = 8'h00;
      next_r.nb_tgt = 8'h00;
    end

    // Indicators only meaningful once soft-start is over
    next_r.core_pg = (r.st == SS_RUN) && !r.core_off && (r.core_flt == 4'h0);
    next_r.nb_pg = (r.st == SS_RUN) && !r.nb_off && (r.nb_flt == 4'h0);
    next_r.ocp_n = !((r.st == SS_RUN) && (r.core_flt[`FLT_OC] || r.nb_flt[`FLT_OC]));

    // Converter scan; converter runs on aclk so its done needs no sync
    next_r.adc_start = 1'b0;
    if (!r.adc_busy) begin
      next_r.adc_busy = 1'b1;
      next_r.adc_start = 1'b1;
    end else if (adc_done) begin
      next_r.adc_res[r.adc_sel] = adc_code;
      next_r.adc_sel = (r.adc_sel == `ADC_LAST_CH) ? 4'h0 : r.adc_sel + 4'h1;
      next_r.adc_start = 1'b1;
    end

    // Register writes: address and data in either order
    if (axi_req.awvalid && r.rsp.awready) begin
      next_r.aw_ok = 1'b1;
      next_r.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && r.rsp.wready) begin
      next_r.w_ok = 1'b1;
      next_r.w_data = axi_req.wdata;
      next_r.w_strb = axi_req.wstrb;
    end
    if (axi_req.bready && r.rsp.bvalid) begin
      next_r.rsp.bvalid = 1'b0;
    end
    wr_fire = r.aw_ok && r.w_ok && !r.rsp.bvalid;
    waddr = {r.aw_addr[7:2], 2'b00};
    wmerged = 32'h0;
    if (wr_fire) begin
      next_r.aw_ok = 1'b0;
      next_r.w_ok = 1'b0;
      next_r.rsp.bvalid = 1'b1;
      next_r.rsp.bresp = `RESP_OKAY;
      case (waddr)
        `REG_CTRL: begin
          wmerged = merge_strb({23'h0, r.prot_en, r.slew_div}, r.w_data, r.w_strb);
          next_r.slew_div = wmerged[7:0];
          next_r.prot_en = wmerged[`CTRL_PROT_EN_BIT];
        end
        `REG_OC_LIMIT: begin
          wmerged = merge_strb({22'h0, r.oc_lim}, r.w_data, r.w_strb);
          next_r.oc_lim = wmerged[9:0];
        end
        `REG_IRQ_CLEAR: begin
          clr = r.w_strb[0] ? r.w_data[3:0] : 4'h0;
        end
        `REG_IRQ_ENABLE: begin
          if (r.w_strb[0]) begin
            next_r.irq_en = r.w_data[3:0];
          end
        end
        `REG_STATUS, `REG_FAULT, `REG_IRQ_STATUS: begin
          next_r.rsp.bresp = `RESP_OKAY;
        end
        default: begin
          next_r.rsp.bresp = `RESP_SLVERR;
        end
      endcase
    end
    next_r.rsp.awready = !next_r.aw_ok;
    next_r.rsp.wready = !next_r.w_ok;

    // Set beats clear in the same cycle
    next_r.irq_stat = (r.irq_stat & ~clr) | events;
    next_r.irq = |(r.irq_stat & r.irq_en);

    // Register reads
    raddr = {axi_req.araddr[7:2], 2'b00};
    aidx = 4'((raddr - `REG_ADC_BASE) >> 2);
    if (axi_req.rready && r.rsp.rvalid) begin
      next_r.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && r.rsp.arready) begin
      next_r.rsp.rvalid = 1'b1;
      next_r.rsp.rresp = `RESP_OKAY;
      next_r.rsp.rdata = 32'h0;
      case (raddr)
        `REG_CTRL: next_r.rsp.rdata = {23'h0, r.prot_en, r.slew_div};
        `REG_OC_LIMIT: next_r.rsp.rdata = {22'h0, r.oc_lim};
        `REG_STATUS: begin
          next_r.rsp.rdata[7:0] = r.core_ref;
          next_r.rsp.rdata[`STAT_NB_LSB +: 8] = r.nb_ref;
          next_r.rsp.rdata[`STAT_CORE_OFF_BIT] = r.core_off;
          next_r.rsp.rdata[`STAT_NB_OFF_BIT] = r.nb_off;
          next_r.rsp.rdata[`STAT_STATE_LSB +: 2] = r.st;
        end
        `REG_FAULT: next_r.rsp.rdata = {24'h0, r.nb_flt, r.core_flt};
        `REG_IRQ_STATUS: next_r.rsp.rdata = {28'h0, r.irq_stat};
        `REG_IRQ_ENABLE: next_r.rsp.rdata = {28'h0, r.irq_en};
        `REG_IRQ_CLEAR: next_r.rsp.rdata = 32'h0;
        default: begin
          if (raddr >= `REG_ADC_BASE && raddr < `REG_ADC_END) begin
            next_r.rsp.rdata = {22'h0, r.adc_res[aidx]};
          end else begin
            next_r.rsp.rresp = `RESP_SLVERR;
          end
        end
      endcase
    end
    next_r.rsp.arready = !next_r.rsp.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.core_off <= 1'b1;
      r.nb_off <= 1'b1;
      r.slew_div <= `SLEW_DIV_RESET;
      r.prot_en <= 1'b1;
      r.oc_lim <= `OC_LIMIT_RESET;
      r.ocp_n <= 1'b1;
      r.telem <= 1'b1;
      r.rsp.awready <= 1'b1;
      r.rsp.wready <= 1'b1;
      r.rsp.arready <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign serial_telemetry_pin = r.telem;
  assign adc_select = r.adc_sel;
  assign adc_start = r.adc_start;
  assign core_reference = r.core_ref;
  assign core_off = r.core_off;
  assign nb_reference = r.nb_ref;
  assign nb_off = r.nb_off;
  assign core_power_good = r.core_pg;
  assign nb_power_good = r.nb_pg;
  assign overcurrent_flag_n = r.ocp_n;
  assign irq = r.irq;
  assign axi_rsp = r.rsp;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_decode;
    @(posedge aclk) disable iff (!aresetn)
    frame.valid && frame.sel[1] && !r.u2 && frame.code <= 8'hf8
      |=> !core_off && r.core_tgt == 8'(8'hf8 - $past(frame.code));
  endproperty
  a_decode: assert property (p_decode) else $error("core code decode wrong");

  property p_off_code;
    @(posedge aclk) disable iff (!aresetn)
    frame.valid && frame.sel[0] && frame.code > 8'hf8 |=> nb_off;
  endproperty
  a_off_code: assert property (p_off_code) else $error("off code not honoured");

  property p_soft_gate;
    @(posedge aclk) disable iff (!aresetn)
    r.st == SS_IDLE && (!r.e2 || r.u2) |=> r.st == SS_IDLE;
  endproperty
  a_soft_gate: assert property (p_soft_gate) else $error("soft-start without enable");

  property p_ind_idle;
    @(posedge aclk) disable iff (!aresetn)
    r.st != SS_RUN |=> !core_power_good && !nb_power_good && overcurrent_flag_n;
  endproperty
  a_ind_idle: assert property (p_ind_idle) else $error("indicator before soft-start");

  property p_ocp;
    @(posedge aclk) disable iff (!aresetn)
    r.st == SS_RUN && r.core_flt[`FLT_OC] |=> !overcurrent_flag_n;
  endproperty
  a_ocp: assert property (p_ocp) else $error("overcurrent flag not low");

  property p_slew;
    @(posedge aclk) disable iff (!aresetn)
    r.st != SS_IDLE |=> core_reference == $past(core_reference)
      || core_reference == 8'($past(core_reference) + 8'h01)
      || core_reference == 8'($past(core_reference) - 8'h01);
  endproperty
  a_slew: assert property (p_slew) else $error("reference jumped");

  property p_adc_scan;
    @(posedge aclk) disable iff (!aresetn)
    adc_start |-> adc_select <= 4'h8 ##1 !adc_start;
  endproperty
  a_adc_scan: assert property (p_adc_scan) else $error("converter channel out of range");

  property p_lockout;
    @(posedge aclk) disable iff (!aresetn)
    r.u2 |=> r.st == SS_IDLE && core_off && nb_off ##1 core_reference == 8'h00;
  endproperty
  a_lockout: assert property (p_lockout) else $error("lockout ignored");

  property p_off_hold;
    @(posedge aclk) disable iff (!aresetn)
    core_off && !(frame.valid && frame.sel[1]) |=> core_off;
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("core left off without code");

endmodule
`default_nettype wire

//--- verif/cpu_link_master.sv
// Behavioural CPU side of the serial voltage-code link
`timescale 1ns/100ps
`default_nettype none
module cpu_link_master (
  // Clock
  input wire logic aclk,
  // Link pins, idle high
  output logic link_clk,
  output logic link_data
);
  // ------------------------------
  // Frame sender
  // ------------------------------
  initial begin
    link_clk = 1'b1;
    link_data = 1'b1;
  end
  // Levels held h cycles; 1 is the fastest the receiver allows
  task automatic send(input logic [1:0] sel, input logic [7:0] code, input int h);
    logic [10:0] f;
    f = {sel, code, 1'b1};
    repeat (h) @(posedge aclk);
    link_data <= 1'b0;
    for (int i = 10; i >= 0; i--) begin
      repeat (h) @(posedge aclk);
      link_clk <= 1'b0;
      repeat (h) @(posedge aclk);
      link_data <= f[i];
      repeat (h) @(posedge aclk);
      link_clk <= 1'b1;
    end
  endtask
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench of the reference control core
`timescale 1ns/100ps
`default_nettype none
`include "vref_consts.svh"
module tb_top
  import vref_pkg::*;
;
  // ------------------------------
  // Signals and helpers
  // ------------------------------
  logic aclk = 1'b0, aresetn = 1'b0, en = 1'b0, lockout = 1'b1, adc_done = 1'b0, mon = 1'b0;
  logic lc, ld, tel, adc_start, coff, noff, cpg, npg, ocn, irq;
  logic [3:0] adc_sel;
  logic [9:0] adc_code = 10'h000, load = 10'h000;
  logic [7:0] cref, nref, prev, c, ce, ne;
  logic [7:0] tbl [5] = '{8'h00, 8'hf8, 8'hf9, 8'hff, 8'h00};
  logic [31:0] q, seed = 32'h0001_5833;
  logic [1:0] r;
  axi_req_t req = '0;
  axi_rsp_t rsp;
  int fail_count = 0, checks = 0, n;

  always #5 aclk = ~aclk;
  cpu_link_master i_cpu_link_master (.aclk(aclk), .link_clk(lc), .link_data(ld));
  voltage_code_reference_control i_voltage_code_reference_control (
    .aclk(aclk), .aresetn(aresetn), .enable_pin(en), .supply_undervoltage_lockout(lockout),
    .serial_vid_clock_pin(lc), .serial_vid_data_pin(ld), .serial_telemetry_pin(tel),
    .adc_select(adc_sel), .adc_start(adc_start), .adc_code(adc_code), .adc_done(adc_done),
    .core_reference(cref), .core_off(coff), .nb_reference(nref), .nb_off(noff),
    .core_power_good(cpg), .nb_power_good(npg), .overcurrent_flag_n(ocn), .irq(irq),
    .axi_req(req), .axi_rsp(rsp));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Off codes slew to zero as well
  function automatic logic [7:0] eref(input logic [7:0] k);
    return k > 8'hf8 ? 8'h00 : 8'hf8 - k;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Handshakes judged at the falling edge so the rising edge never races
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic [1:0] rr);
    logic ta, tw, tb;
    @(posedge aclk);
    if (w) begin
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.bready <= 1'b1;
    end else begin
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
    end
    tb = 1'b0;
    for (int k = 0; k < 40 && !tb; k++) begin
      @(negedge aclk);
      ta = w ? req.awvalid && rsp.awready : req.arvalid && rsp.arready;
      tw = req.wvalid && rsp.wready;
      tb = w ? rsp.bvalid : rsp.rvalid;
      rq = rsp.rdata;
      rr = w ? rsp.bresp : rsp.rresp;
      @(posedge aclk);
      if (ta) begin
        req.awvalid <= 1'b0;
        req.arvalid <= 1'b0;
      end
      if (tw) req.wvalid <= 1'b0;
      if (tb) begin
        req.bready <= 1'b0;
        req.rready <= 1'b0;
      end
    end
    if (!tb) begin
      chk(0, 1, "bus timeout");
      end_sim();
    end
  endtask
  task automatic ramp(input logic [7:0] ce_x, input logic [7:0] ne_x);
    for (n = 0; n < 4000 && (cref !== ce_x || nref !== ne_x); n++) @(posedge aclk);
    chk(n < 4000, 1'b1, "ramp timeout");
    if (n >= 4000) end_sim();
  endtask

  // Converter answers one edge later; senses echo the references
  always @(posedge aclk) begin
    adc_done <= adc_start;
    prev <= cref;
    if (mon && cref !== prev) chk(cref - prev == 8'h01 || prev - cref == 8'h01, 1, "slew");
    case (adc_sel)
      4'h5: adc_code <= load;
      4'h7: adc_code <= {2'b00, cref};
      4'h8: adc_code <= {2'b00, nref};
      default: adc_code <= 10'(rnd() & 32'h0000_01ff);
    endcase
  end

  // ------------------------------
  // Scenarios
  // ------------------------------
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    bus(0, `REG_STATUS, 0, q, r);
    chk(q, 32'h0003_0000, "reset status");
    chk({tel, ocn, irq, cpg, npg}, 5'b11000, "reset pins");
    bus(0, `REG_CTRL, 0, q, r);
    chk(q, {23'h0, 1'b1, `SLEW_DIV_RESET}, "ctrl reset");
    bus(0, 8'h80, 0, q, r);
    chk(r, `RESP_SLVERR, "unmapped");
    bus(1, `REG_IRQ_ENABLE, 0, q, r);
    en <= 1'b1;
    repeat (40) @(posedge aclk);
    bus(0, `REG_STATUS, 0, q, r);
    chk(q[25:24], SS_IDLE, "lockout holds");
    $display("test reset done");
    lockout <= 1'b0;
    mon <= 1'b1;
    c = 8'(rnd() % 249);
    i_cpu_link_master.send(2'b11, c, 3);
    chk(tel, 1'b0, "acknowledge");
    chk(irq, 1'b0, "masked");
    bus(1, `REG_IRQ_ENABLE, 1, q, r);
    repeat (3) @(posedge aclk);
    chk({irq, tel}, 2'b11, "frame irq");
    bus(1, `REG_IRQ_CLEAR, 32'h0000_000f, q, r);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0, "cleared");
    ce = eref(c);
    ne = ce;
    ramp(ce, ne);
    repeat (4) @(posedge aclk);
    chk({cpg, npg, ocn}, 3'b111, "power good");
    $display("test soft start done");
    tbl[4] = 8'(rnd() % 249);
    for (int i = 0; i < 10; i++) begin
      c = tbl[i >> 1];
      if (i[0]) ne = eref(c);
      else ce = eref(c);
      i_cpu_link_master.send(i[0] ? 2'b01 : 2'b10, c, 3 + i % 4);
      ramp(ce, ne);
      chk(i[0] ? noff : coff, c > 8'hf8, "off code");
      chk(i[0] ? nref : cref, eref(c), "level");
    end
    $display("test codes done");
    load <= 10'h200;
    repeat (100) @(posedge aclk);
    chk(ocn, 1'b1, "at limit");
    load <= 10'h201;
    for (n = 0; n < 100 && ocn !== 1'b0; n++) @(posedge aclk);
    chk(ocn, 1'b0, "overcurrent");
    if (n >= 100) end_sim();
    repeat (4) @(posedge aclk);
    chk(cpg, 1'b0, "fault drops good");
    bus(0, `REG_FAULT, 0, q, r);
    chk(q, 32'h1 << `FLT_OC, "fault latch");
    bus(0, 8'(`REG_ADC_BASE + 4 * `ADC_CH_CORE_CURR), 0, q, r);
    chk(q, {22'h0, load}, "converter result");
    $display("test overcurrent done");
    mon <= 1'b0;
    lockout <= 1'b1;
    repeat (8) @(posedge aclk);
    chk({coff, noff, cref, nref, npg}, {2'b11, 17'h0}, "lockout");
    lockout <= 1'b0;
    en <= 1'b0;
    repeat (40) @(posedge aclk);
    bus(0, `REG_STATUS, 0, q, r);
    chk(q[25:24], SS_IDLE, "disabled");
    $display("test lockout done");
    end_sim();
  end
endmodule
`default_nettype wire
